// ### src/spg_power_gating.sv
// STOP-state power sequencer with an AXI4-Lite register slave.
//
// The register addresses and the AXI4-Lite register port were chosen for this implementation.
`timescale 1ns/100ps
module spg_power_gating #(
  parameter int SETTLE_RESET_CYCLES_P = spg_pkg::SETTLE_RESET_CYCLES
) (
  input wire logic clock, // System clock, 10 MHz.
  input wire logic rst, // Synchronous reset, active high.
  input wire logic [spg_pkg::ADDR_W-1:0] s_axi_awaddr, // Write address.
  input wire logic s_axi_awvalid, // Write address valid.
  output logic s_axi_awready, // Write address ready.
  input wire logic [31:0] s_axi_wdata, // Write data.
  input wire logic [3:0] s_axi_wstrb, // Write byte strobes.
  input wire logic s_axi_wvalid, // Write data valid.
  output logic s_axi_wready, // Write data ready.
  output logic [1:0] s_axi_bresp, // Write response.
  output logic s_axi_bvalid, // Write response valid.
  input wire logic s_axi_bready, // Write response ready.
  input wire logic [spg_pkg::ADDR_W-1:0] s_axi_araddr, // Read address.
  input wire logic s_axi_arvalid, // Read address valid.
  output logic s_axi_arready, // Read address ready.
  output logic [31:0] s_axi_rdata, // Read data.
  output logic [1:0] s_axi_rresp, // Read response.
  output logic s_axi_rvalid, // Read data valid.
  input wire logic s_axi_rready, // Read data ready.
  input wire logic nmiPin, // Non-maskable request pin.
  input wire logic wdtNmi, // Second watchdog non-maskable request.
  input wire logic [spg_pkg::EXT_W-1:0] extIrq, // External request pins.
  input wire logic keyIrq, // Key interrupt request.
  input wire logic [spg_pkg::PERIPH_W-1:0] periphIrq, // Requests of survivable units.
  output logic [spg_pkg::UNIT_W-1:0] unitRun, // Clock enable for each unit.
  output logic mainOscEnable, // Main oscillator enable.
  output logic subOscEnable, // Subclock oscillator enable.
  output logic portHold, // Port pins hold their state.
  output logic dataRetain, // Internal data held, no updates.
  output logic rtoBufferLock // Realtime output buffers locked.
);
  import spg_pkg::*;

  localparam logic [SETTLE_W-1:0] SETTLE_RESET_COUNT = SETTLE_W'(SETTLE_RESET_CYCLES_P);
  localparam logic [SETTLE_W-1:0] SETTLE_UNIT = SETTLE_W'(SETTLE_RESET_CYCLES_P >> SETTLE_SEL_RESET);

  spg_state_t state;
  logic [SETTLE_W-1:0] settleCount;
  logic [0:0] selectReg;
  logic [7:0] controlReg;
  logic [2:0] settleSel;
  logic [CFG_W-1:0] configReg;
  logic [1:0] wakeCause;
  logic [ADDR_W-1:0] awAddrHeld;
  logic [31:0] wDataHeld;
  logic [3:0] wStrbHeld;
  logic awHeld;
  logic wHeld;
  logic doWrite;
  logic [2:0] wrId;
  logic [31:0] wrWord;
  logic [WAKE_W-1:0] wakeSync;
  logic [UNIT_W-1:0] survive;
  logic [UNIT_W-1:0] next_unitRun;
  logic [PERIPH_W-1:0] periphAlive;
  logic pinNmiWake;
  logic wdtNmiWake;
  logic maskWake;
  logic enterStop;

  //////////////////////////////////////////////////////////////////////////////
  // Decoding shared by the read and the write path.
  function automatic logic [2:0] decodeReg(input logic [ADDR_W-1:0] addr);
    if (addr == OFS_SELECT) begin
      return REG_SELECT;
    end else if (addr == OFS_CONTROL) begin
      return REG_CONTROL;
    end else if (addr == OFS_SETTLE) begin
      return REG_SETTLE;
    end else if (addr == OFS_CONFIG) begin
      return REG_CONFIG;
    end else if (addr == OFS_STATUS) begin
      return REG_STATUS;
    end else begin
      return REG_NONE;
    end
  endfunction

  function automatic logic [31:0] mergeStrb(input logic [31:0] old, input logic [31:0] data,
                                            input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        res[8*b +: 8] = data[8*b +: 8];
      end
    end
    return res;
  endfunction

  function automatic logic [31:0] readWord(input logic [2:0] id, input logic [0:0] sel,
                                           input logic [7:0] ctl, input logic [2:0] sts,
                                           input logic [CFG_W-1:0] cfg, input spg_state_t st,
                                           input logic [1:0] cause);
    logic [31:0] res;
    res = 32'h00000000;
    case (id)
      REG_SELECT: begin
        res[0] = sel[0];
      end
      REG_CONTROL: begin
        // The halt request reads back as zero; it only acts on the write.
        res[7:0] = ctl & CONTROL_WMASK;
      end
      REG_SETTLE: begin
        res[2:0] = sts;
      end
      REG_CONFIG: begin
        res[CFG_W-1:0] = cfg;
      end
      REG_STATUS: begin
        res[1:0] = st;
        res[3:2] = cause;
      end
      default: begin
        res = 32'h00000000;
      end
    endcase
    return res;
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // Wake inputs come from pins and other clock domains.
  spg_pin_sync #(
    .WIDTH(WAKE_W)
  ) uSync (
    .clock(clock),
    .rst(rst),
    .pinIn({periphIrq, keyIrq, extIrq, wdtNmi, nmiPin}),
    .syncOut(wakeSync)
  );

  //////////////////////////////////////////////////////////////////////////////
  // Which units keep their clock while the main oscillator is off.
  always_comb begin
    logic sub;
    logic t16b;
    logic [1:0] t8;
    t8 = 2'b00;
    sub = configReg[CFG_SUB_USED];
    t16b = sub & configReg[CFG_T16B_WATCH] & configReg[CFG_WATCH_SUB];
    for (int n = 0; n < 2; n++) begin
      t8[n] = configReg[CFG_T8_PIN + n] | (sub & configReg[CFG_T8_T16B + n] & t16b);
    end
    survive = UNIT_RESET;
    survive[U_T16B] = t16b;
    survive[U_T8A] = t8[0];
    survive[U_T8B] = t8[1];
    survive[U_THB] = sub & configReg[CFG_THB_SUB];
    survive[U_WATCH] = sub & configReg[CFG_WATCH_SUB];
    survive[U_WDTB] = sub & configReg[CFG_WDTB_SUB];
    survive[U_CSIA] = configReg[CFG_CSI_EXT];
    survive[U_CSIB] = configReg[CFG_CSI_EXT + 1];
    survive[U_UARTA] = configReg[CFG_UARTA_EXT];
    survive[U_RTO] = configReg[CFG_RTO_T8] & t8[configReg[CFG_RTO_SEL]];
    survive[U_KEY] = 1'b1;
    // The converter is never clocked in STOP; software must have stopped it first.
    survive[U_ADC] = 1'b0;
  end

  always_comb begin
    next_unitRun = (state == SPG_RUN) ? UNIT_ALL : survive;
  end

  // Only requests of units that are still clocked can wake the device.
  always_comb begin
    periphAlive[0] = survive[U_T16B];
    periphAlive[1] = survive[U_T8A];
    periphAlive[2] = survive[U_T8B];
    periphAlive[3] = survive[U_THB];
    periphAlive[4] = survive[U_WATCH];
    periphAlive[5] = survive[U_CSIA];
    periphAlive[6] = survive[U_CSIB];
    periphAlive[7] = survive[U_UARTA];
  end

  always_comb begin
    pinNmiWake = wakeSync[WK_PIN_NMI] & ~controlReg[CTL_PIN_NMI];
    wdtNmiWake = wakeSync[WK_WDT_NMI] & survive[U_WDTB] & ~controlReg[CTL_WDT_NMI];
    maskWake = ~controlReg[CTL_MASKABLE] & ((|wakeSync[WK_EXT +: EXT_W]) | wakeSync[WK_KEY] |
               (|(wakeSync[WK_PERIPH +: PERIPH_W] & periphAlive)));
  end

  //////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite write path: address and data are taken in either order.
  always_comb begin
    doWrite = awHeld & wHeld & ~s_axi_bvalid;
    wrId = decodeReg(awAddrHeld);
    wrWord = mergeStrb(readWord(wrId, selectReg, controlReg, settleSel, configReg, state,
                                wakeCause), wDataHeld, wStrbHeld);
    enterStop = doWrite & (wrId == REG_CONTROL) & wStrbHeld[0] & wrWord[CTL_HALT] &
                selectReg[0] & (state == SPG_RUN);
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      s_axi_awready <= 1'b0;
      awHeld <= 1'b0;
      awAddrHeld <= '0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      s_axi_awready <= 1'b0;
      awHeld <= 1'b1;
      awAddrHeld <= s_axi_awaddr;
    end else if (doWrite) begin
      awHeld <= 1'b0;
    end else if (!awHeld && !s_axi_bvalid) begin
      s_axi_awready <= 1'b1;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      s_axi_wready <= 1'b0;
      wHeld <= 1'b0;
      wDataHeld <= 32'h00000000;
      wStrbHeld <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      s_axi_wready <= 1'b0;
      wHeld <= 1'b1;
      wDataHeld <= s_axi_wdata;
      wStrbHeld <= s_axi_wstrb;
    end else if (doWrite) begin
      wHeld <= 1'b0;
    end else if (!wHeld && !s_axi_bvalid) begin
      s_axi_wready <= 1'b1;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else if (doWrite) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= (wrId == REG_NONE) ? RESP_SLVERR : RESP_OKAY;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Register contents are only reset by rst, never by STOP entry or exit.
  always_ff @(posedge clock) begin
    if (rst) begin
      selectReg <= SELECT_RESET;
      controlReg <= CONTROL_RESET;
      settleSel <= SETTLE_SEL_RESET;
      configReg <= CONFIG_RESET;
    end else if (doWrite) begin
      if (wrId == REG_SELECT) begin
        selectReg <= wrWord[0:0];
      end else if (wrId == REG_CONTROL) begin
        controlReg <= wrWord[7:0] & CONTROL_WMASK;
      end else if (wrId == REG_SETTLE) begin
        settleSel <= (wrWord[2:0] > SETTLE_SEL_MAX) ? SETTLE_SEL_MAX : wrWord[2:0];
      end else if (wrId == REG_CONFIG) begin
        configReg <= wrWord[CFG_W-1:0];
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite read path: data is captured with the address.
  always_ff @(posedge clock) begin
    if (rst) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= readWord(decodeReg(s_axi_araddr), selectReg, controlReg, settleSel,
                              configReg, state, wakeCause);
      s_axi_rresp <= (decodeReg(s_axi_araddr) == REG_NONE) ? RESP_SLVERR : RESP_OKAY;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end else if (!s_axi_rvalid) begin
      s_axi_arready <= 1'b1;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Power state sequencing.
  always_ff @(posedge clock) begin
    if (rst) begin
      state <= SPG_SETTLE;
      settleCount <= SETTLE_RESET_COUNT;
      wakeCause <= CAUSE_RESET;
    end else begin
      case (state)
        SPG_RUN: begin
          if (enterStop) begin
            state <= SPG_STOP;
          end
        end
        SPG_STOP: begin
          // A request level is enough; it stays pending for the CPU after wake.
          if (pinNmiWake || wdtNmiWake || maskWake) begin
            state <= SPG_SETTLE;
            settleCount <= SETTLE_UNIT << settleSel;
            wakeCause <= pinNmiWake ? CAUSE_PIN_NMI :
                         (wdtNmiWake ? CAUSE_WDT_NMI : CAUSE_MASKABLE);
          end
        end
        SPG_SETTLE: begin
          if (settleCount <= SETTLE_W'(1)) begin
            state <= SPG_RUN;
            settleCount <= '0;
          end else begin
            settleCount <= settleCount - SETTLE_W'(1);
          end
        end
        default: begin
          state <= SPG_SETTLE;
          settleCount <= SETTLE_RESET_COUNT;
        end
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Registered gating outputs; they lag the state by one cycle.
  always_ff @(posedge clock) begin
    if (rst) begin
      unitRun <= UNIT_RESET;
      mainOscEnable <= 1'b1;
      subOscEnable <= 1'b1;
      portHold <= 1'b0;
      dataRetain <= 1'b0;
      rtoBufferLock <= 1'b0;
    end else begin
      unitRun <= next_unitRun;
      mainOscEnable <= (state != SPG_STOP);
      subOscEnable <= (state != SPG_STOP) | configReg[CFG_SUB_USED];
      portHold <= (state != SPG_RUN);
      dataRetain <= (state != SPG_RUN);
      rtoBufferLock <= (state != SPG_RUN);
    end
  end

endmodule

// ### inc/spg_pkg.sv
// Shared constants, register map and state type for the STOP-state power-gating block.
package spg_pkg;

  //////////////////////////////////////////////////////////////////////////////
  // Timing.
  localparam int CLOCK_PERIOD_NS = 100;
  // Reset default settle time, 2^15/fx with fx = 4 MHz, is 8.192 ms.
  localparam int SETTLE_RESET_NS = 8192000;
  localparam int SETTLE_RESET_CYCLES = (SETTLE_RESET_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
  localparam int SETTLE_W = 20;

  //////////////////////////////////////////////////////////////////////////////
  // Register map and bus answers.
  localparam int ADDR_W = 8;
  localparam logic [7:0] OFS_SELECT = 8'h00;
  localparam logic [7:0] OFS_CONTROL = 8'h04;
  localparam logic [7:0] OFS_SETTLE = 8'h08;
  localparam logic [7:0] OFS_CONFIG = 8'h0C;
  localparam logic [7:0] OFS_STATUS = 8'h10;
  localparam logic [2:0] REG_SELECT = 3'h0;
  localparam logic [2:0] REG_CONTROL = 3'h1;
  localparam logic [2:0] REG_SETTLE = 3'h2;
  localparam logic [2:0] REG_CONFIG = 3'h3;
  localparam logic [2:0] REG_STATUS = 3'h4;
  localparam logic [2:0] REG_NONE = 3'h7;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Control register fields.
  localparam int CTL_HALT = 0;
  localparam int CTL_MASKABLE = 4;
  localparam int CTL_PIN_NMI = 5;
  localparam int CTL_WDT_NMI = 6;
  localparam logic [7:0] CONTROL_RESET = 8'h00;
  localparam logic [7:0] CONTROL_WMASK = 8'h70;
  localparam logic [0:0] SELECT_RESET = 1'h0;

  // Settle select: count = unit << select, select saturates at the maximum.
  localparam logic [2:0] SETTLE_SEL_RESET = 3'h2;
  localparam logic [2:0] SETTLE_SEL_MAX = 3'h4;

  // Configuration register fields (clock sources of the units that may survive).
  localparam int CFG_SUB_USED = 0;
  localparam int CFG_T16B_WATCH = 1;
  localparam int CFG_WATCH_SUB = 2;
  localparam int CFG_T8_PIN = 3;
  localparam int CFG_T8_T16B = 5;
  localparam int CFG_THB_SUB = 7;
  localparam int CFG_WDTB_SUB = 8;
  localparam int CFG_CSI_EXT = 9;
  localparam int CFG_UARTA_EXT = 11;
  localparam int CFG_RTO_T8 = 12;
  localparam int CFG_RTO_SEL = 13;
  localparam int CFG_W = 14;
  localparam logic [13:0] CONFIG_RESET = 14'h0000;

  //////////////////////////////////////////////////////////////////////////////
  // Unit run-enable indices.
  localparam int U_CPU = 0;
  localparam int U_PATCH = 1;
  localparam int U_INTC = 2;
  localparam int U_GENTMR = 3;
  localparam int U_T16A = 4;
  localparam int U_T16B = 5;
  localparam int U_T8A = 6;
  localparam int U_T8B = 7;
  localparam int U_THA = 8;
  localparam int U_THB = 9;
  localparam int U_WATCH = 10;
  localparam int U_WDTA = 11;
  localparam int U_WDTB = 12;
  localparam int U_CSIA = 13;
  localparam int U_CSIB = 14;
  localparam int U_SAU = 15;
  localparam int U_I2C = 16;
  localparam int U_UARTA = 17;
  localparam int U_UARTB = 18;
  localparam int U_RTO = 19;
  localparam int U_KEY = 20;
  localparam int U_ADC = 21;
  localparam int U_REG = 22;
  localparam int UNIT_W = 23;
  localparam logic [22:0] UNIT_RESET = 23'h000000;
  localparam logic [22:0] UNIT_ALL = 23'h7FFFFF;

  // Wake request vector layout.
  localparam int WK_PIN_NMI = 0;
  localparam int WK_WDT_NMI = 1;
  localparam int WK_EXT = 2;
  localparam int EXT_W = 7;
  localparam int WK_KEY = 9;
  localparam int WK_PERIPH = 10;
  localparam int PERIPH_W = 8;
  localparam int WAKE_W = 18;

  // Wake cause codes shown in status.
  localparam logic [1:0] CAUSE_RESET = 2'h0;
  localparam logic [1:0] CAUSE_PIN_NMI = 2'h1;
  localparam logic [1:0] CAUSE_WDT_NMI = 2'h2;
  localparam logic [1:0] CAUSE_MASKABLE = 2'h3;

  typedef enum logic [1:0] {
    SPG_RUN = 2'b00,
    SPG_STOP = 2'b01,
    SPG_SETTLE = 2'b10
  } spg_state_t;

endpackage

// ### src/spg_pin_sync.sv
// Three-stage input synchroniser that passes a bit once its last two stages agree.
`timescale 1ns/100ps
module spg_pin_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clock, // System clock.
  input wire logic rst, // Synchronous reset, active high.
  input wire logic [WIDTH-1:0] pinIn, // Asynchronous inputs.
  output logic [WIDTH-1:0] syncOut // Filtered, synchronised inputs.
);

  logic [WIDTH-1:0] stageA;
  logic [WIDTH-1:0] stageB;
  logic [WIDTH-1:0] stageC;

  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : gBit
      // Stage A feeds only stage B, so a metastable value never reaches any logic.
      always_ff @(posedge clock) begin
        if (rst) begin
          stageA[i] <= 1'b0;
          stageB[i] <= 1'b0;
          stageC[i] <= 1'b0;
          syncOut[i] <= 1'b0;
        end else begin
          stageA[i] <= pinIn[i];
          stageB[i] <= stageA[i];
          stageC[i] <= stageB[i];
          if (stageB[i] == stageC[i]) begin
            syncOut[i] <= stageC[i];
          end
        end
      end
    end
  endgenerate

endmodule

// ### sim/spg_power_gating_chk.sv
// Concurrent checks on the ports of the STOP-state power-gating block.
`timescale 1ns/100ps
module spg_power_gating_chk #(
  parameter int SETTLE_RESET_CYCLES_P = spg_pkg::SETTLE_RESET_CYCLES
) (
  input wire logic clock, // System clock.
  input wire logic rst, // Synchronous reset.
  input wire logic s_axi_bvalid, // Write response valid.
  input wire logic s_axi_bready, // Write response ready.
  input wire logic [1:0] s_axi_bresp, // Write response.
  input wire logic nmiPin, // Pin request.
  input wire logic wdtNmi, // Watchdog request.
  input wire logic [spg_pkg::EXT_W-1:0] extIrq, // External requests.
  input wire logic keyIrq, // Key request.
  input wire logic [spg_pkg::PERIPH_W-1:0] periphIrq, // Unit requests.
  input wire logic [spg_pkg::UNIT_W-1:0] unitRun, // Unit clock enables.
  input wire logic mainOscEnable, // Main oscillator enable.
  input wire logic portHold, // Port hold.
  input wire logic dataRetain, // Data retention.
  input wire logic rtoBufferLock // Output buffer lock.
);
  import spg_pkg::*;
  // Units that only ever run from the main clock: bits 0-4, 8, 11, 15, 16, 18 and 22.
  localparam logic [22:0] HALTED = 23'h45891F;
  logic [3:0] quietCnt;
  logic [19:0] sinceRst;
  logic fromRst;
  //////////////////////////////////////////////////////////////////////////////
  // A wake may only follow a request seen in the last few cycles, since requests are levels.
  always_ff @(posedge clock) begin
    if (rst || nmiPin || wdtNmi || (|extIrq) || keyIrq || (|periphIrq)) begin
      quietCnt <= 4'h0;
    end else if (quietCnt != 4'hF) begin
      quietCnt <= quietCnt + 4'h1;
    end
  end
  always_ff @(posedge clock) begin
    if (rst) begin
      sinceRst <= 20'h00000;
      fromRst <= 1'b1;
    end else if (fromRst) begin
      sinceRst <= sinceRst + 20'h00001;
      fromRst <= (unitRun != UNIT_ALL);
    end
  end
  //////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  a_main_units_off: assert property (portHold |->
    (unitRun & HALTED) == 23'h000000)
    else $error("main-clock unit clocked while held");
  a_adc_stopped: assert property (portHold |-> !unitRun[U_ADC])
    else $error("converter clocked while held");
  a_key_alive: assert property (portHold |-> unitRun[U_KEY])
    else $error("key logic stopped while held");
  a_osc_off_held: assert property (!mainOscEnable |-> portHold && !unitRun[U_CPU])
    else $error("main oscillator off outside the stop state");
  a_hold_lock_tied: assert property (
    portHold == dataRetain && dataRetain == rtoBufferLock)
    else $error("hold, retain and lock disagree");
  a_wake_has_cause: assert property ($rose(mainOscEnable) |->
    $past(rst) || quietCnt < 4'hA)
    else $error("wake without a request");
  a_reset_plain: assert property (disable iff (1'b0) rst |=>
    unitRun == 23'h000000 && mainOscEnable && !portHold && !s_axi_bvalid)
    else $error("reset state wrong");
  a_reset_settle: assert property (fromRst && unitRun == UNIT_ALL |->
    sinceRst >= SETTLE_RESET_CYCLES_P && sinceRst <= SETTLE_RESET_CYCLES_P + 3)
    else $error("reset settle time wrong");
  a_bresp_stands: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
endmodule
bind spg_power_gating spg_power_gating_chk #(.SETTLE_RESET_CYCLES_P(SETTLE_RESET_CYCLES_P)) chk_i (
  .clock, .rst, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .nmiPin, .wdtNmi, .extIrq, .keyIrq,
  .periphIrq, .unitRun, .mainOscEnable, .portHold, .dataRetain, .rtoBufferLock);

// ### sim/tb.sv
// Self-checking bench for the STOP-state power-gating block.
`timescale 1ns/100ps
`define CHECK(got, exp) begin \
  checkCount++; \
  if ((got) !== (exp)) begin \
    badCount++; \
    $display("unexpected at %0t: got %h exp %h", $time, got, exp); \
  end \
end
module tb;
  import spg_pkg::*;
  localparam int P = 40;
  logic clock = 0, rst = 1, awv = 0, wv = 0, bready = 0, arv = 0, rready = 0;
  logic awready, wready, bvalid, arready, rvalid, mainOsc, subOsc, hold, retain, lock;
  logic [7:0] awaddr = 0, araddr = 0;
  logic [31:0] wdata = 0, rdata, d;
  logic [1:0] bresp, rresp, r;
  logic nmiPin = 0, wdtNmi = 0, keyIrq = 0;
  logic [6:0] extIrq = 0;
  logic [7:0] periphIrq = 0;
  logic [22:0] unitRun;
  int badCount = 0, checkCount = 0;
  // Per row: configuration, settle select written, control, blocked request, waking request, cause.
  logic [13:0] rCfg [5] = '{14'h0000, 14'h3FFF, 14'h11A6, 14'h0101, 14'h3243};
  logic [2:0] rSel [5] = '{3'h0, 3'h7, 3'h1, 3'h2, 3'h3};
  logic [7:0] rCtl [5] = '{8'h01, 8'h21, 8'h11, 8'h31, 8'h61};
  int rBlk [5] = '{5, 1, 3, 4, 2};
  int rWake [5] = '{4, 3, 1, 2, 5};
  logic [1:0] rCause [5] = '{2'h3, 2'h3, 2'h1, 2'h2, 2'h3};
  spg_power_gating #(.SETTLE_RESET_CYCLES_P(P)) spg_power_gating_i (
    .clock(clock), .rst(rst), .s_axi_awaddr(awaddr), .s_axi_awvalid(awv), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wv), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arv), .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .nmiPin(nmiPin), .wdtNmi(wdtNmi),
    .extIrq(extIrq), .keyIrq(keyIrq), .periphIrq(periphIrq), .unitRun(unitRun),
    .mainOscEnable(mainOsc), .subOscEnable(subOsc), .portHold(hold), .dataRetain(retain),
    .rtoBufferLock(lock));
  initial begin
    forever #50 clock = ~clock;
  end
  //////////////////////////////////////////////////////////////////////////////
  task automatic testDone;
    $display("checks %0d, mismatches %0d", checkCount, badCount);
    if (badCount == 0 && checkCount > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic hang;
    badCount++;
    $display("unexpected at %0t: wait ran out", $time);
    testDone;
  endtask
  task automatic axiWrite(input logic [7:0] a, input logic [31:0] v, input logic [1:0] er);
    int n;
    n = 0;
    awaddr <= a;
    wdata <= v;
    awv <= 1'b1;
    wv <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clock);
      n++;
      if (awv && awready) begin
        awv <= 1'b0;
      end
      if (wv && wready) begin
        wv <= 1'b0;
      end
    end while (!bvalid && n < 50);
    if (n >= 50) hang;
    `CHECK(bresp, er)
  endtask
  task automatic axiRead(input logic [7:0] a);
    int n;
    n = 0;
    araddr <= a;
    arv <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clock);
      n++;
      if (arv && arready) begin
        arv <= 1'b0;
      end
    end while (!rvalid && n < 50);
    if (n >= 50) hang;
    d = rdata;
    r = rresp;
  endtask
  // Counts edges until every unit runs again and compares with the expected settle time.
  task automatic waitRun(input int exp);
    int n;
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (unitRun !== UNIT_ALL && n < 400);
    if (n >= 400) hang;
    `CHECK(n >= exp - 1 && n <= exp + 2, 1'b1)
  endtask
  task automatic setReq(input int code, input logic v);
    case (code)
      1: nmiPin <= v;
      2: wdtNmi <= v;
      3: extIrq[3] <= v;
      4: keyIrq <= v;
      5: periphIrq[5] <= v;
      default: ;
    endcase
  endtask
  function automatic logic [22:0] surv(input logic [13:0] c);
    logic [22:0] u;
    u = 23'h000000;
    u[U_KEY] = 1'b1;
    u[U_T16B] = c[0] & c[1] & c[2];
    u[U_WATCH] = c[0] & c[2];
    u[U_T8A] = c[3] | (c[0] & c[5] & u[U_T16B]);
    u[U_T8B] = c[4] | (c[0] & c[6] & u[U_T16B]);
    u[U_THB] = c[0] & c[7];
    u[U_WDTB] = c[0] & c[8];
    u[U_CSIA] = c[9];
    u[U_CSIB] = c[10];
    u[U_UARTA] = c[11];
    u[U_RTO] = c[12] & (c[13] ? u[U_T8B] : u[U_T8A]);
    return u;
  endfunction
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    int n;
    logic [2:0] s;
    logic [22:0] u;
    repeat (20) @(posedge clock);
    rst <= 1'b0;
    waitRun(P + 1);
    axiRead(OFS_SETTLE);
    `CHECK(d, 32'h00000002)
    axiRead(OFS_STATUS);
    `CHECK(d, 32'h00000000)
    axiRead(8'h14);
    `CHECK(r, RESP_SLVERR)
    axiWrite(8'h18, 32'h00000001, RESP_SLVERR);
    axiWrite(OFS_CONTROL, 32'h00000001, RESP_OKAY);
    repeat (3) @(posedge clock);
    `CHECK(mainOsc, 1'b1)
    for (int i = 0; i < 5; i++) begin
      s = (rSel[i] > SETTLE_SEL_MAX) ? SETTLE_SEL_MAX : rSel[i];
      u = surv(rCfg[i]);
      axiWrite(OFS_CONFIG, {18'h0, rCfg[i]}, RESP_OKAY);
      axiWrite(OFS_SETTLE, {29'h0, rSel[i]}, RESP_OKAY);
      axiRead(OFS_SETTLE);
      `CHECK(d, {29'h0, s})
      axiWrite(OFS_SELECT, 32'h00000001, RESP_OKAY);
      axiWrite(OFS_CONTROL, {24'h0, rCtl[i]}, RESP_OKAY);
      repeat (2) @(posedge clock);
      `CHECK(unitRun[12:0], u[12:0])
      `CHECK(unitRun[22:13], u[22:13])
      `CHECK({mainOsc, subOsc}, {1'b0, rCfg[i][0]})
      `CHECK({hold, retain, lock}, 3'h7)
      axiRead(OFS_STATUS);
      `CHECK(d[1:0], 2'h1)
      setReq(rBlk[i], 1'b1);
      repeat (12) @(posedge clock);
      `CHECK(mainOsc, 1'b0)
      setReq(rBlk[i], 1'b0);
      setReq(rWake[i], 1'b1);
      n = 0;
      do begin
        @(posedge clock);
        n++;
      end while (mainOsc !== 1'b1 && n < 40);
      if (n >= 40) hang;
      setReq(rWake[i], 1'b0);
      waitRun((P >> SETTLE_SEL_RESET) << s);
      `CHECK({hold, retain, lock}, 3'h0)
      axiRead(OFS_STATUS);
      `CHECK(d, {28'h0, rCause[i], 2'h0})
      axiRead(OFS_CONFIG);
      `CHECK(d, {18'h0, rCfg[i]})
    end
    axiWrite(OFS_CONTROL, 32'h00000071, RESP_OKAY);
    keyIrq <= 1'b1;
    repeat (12) @(posedge clock);
    `CHECK(mainOsc, 1'b0)
    rst <= 1'b1;
    repeat (2) @(posedge clock);
    rst <= 1'b0;
    keyIrq <= 1'b0;
    waitRun(P + 1);
    axiRead(OFS_SELECT);
    `CHECK(d, 32'h00000000)
    axiRead(OFS_STATUS);
    `CHECK(d, 32'h00000000)
    testDone;
  end
  initial begin
    repeat (20000) @(posedge clock);
    hang;
  end
endmodule
